// ==== core/nand_host_ctrl.sv ====
// NAND flash host controller: Wishbone registers in, flash bus pins out
`timescale 1ns/1ps
`include "nand_host_params.svh"
module nand_host_ctrl
	import nand_host_pkg::*;
#(
	parameter int unsigned STROBE_CYCLES = `STROBE_CYC,
	parameter int unsigned READ_LOW_CYCLES = `STROBE_CYC + `SYNC_STAGES,
	parameter int unsigned STBY_CYCLES = `STBY_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] io_in_i,
	output logic [7:0] io_out_o,
	output logic io_oe_n_o,
	output logic cle_o,
	output logic ale_o,
	output logic ce_n_o,
	output logic we_n_o,
	output logic read_strobe_n_o,
	output logic wp_n_o,
	input wire logic ready_busy_i
);
	// ****************************************
	// Declarations
	// ****************************************
	ctl_state_type r; // Registered state
	ctl_state_type n; // Next state
	logic [8:0] sync_q; // Synchronised pins
	logic [7:0] io_s; // Bus byte seen by the clock
	logic rdy_s; // Ready line seen by the clock
	logic tmr_load; // Start a timed phase
	logic [`TMR_W-1:0] tmr_count; // Length of that phase
	logic tmr_done; // Last cycle of the phase
	logic req; // New Wishbone request
	logic wr_type; // Requested cycle modifies flash
	logic [2:0] go_op; // Operation written to the op register

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte k of the five-cycle address, pads forced low
	function automatic logic [7:0] addr_byte(input logic [30:0] a, input logic [2:0] k);
		logic [7:0] b;
		b = 8'h00;
		case (k)
			3'h0: b = a[7:0];
			3'h1: b = {4'h0, a[11:8]};
			3'h2: b = a[19:12];
			3'h3: b = a[27:20];
			default: b = {5'h00, a[30:28]};
		endcase
		return b;
	endfunction : addr_byte

	// Commands that start or feed a modify operation
	function automatic logic is_write_cmd(input logic [7:0] c);
		return (c == `CMD_PROG1) || (c == `CMD_PROG2) || (c == `CMD_DUMMY) ||
			(c == `CMD_PROG_P2) || (c == `CMD_COL_WR) ||
			(c == `CMD_ERASE1) || (c == `CMD_ERASE2);
	endfunction : is_write_cmd

	// Byte-lane merge of a Wishbone write
	function automatic logic [31:0] sel_merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return m;
	endfunction : sel_merge

	// ****************************************
	// Submodules
	// ****************************************
	// Pins from outside the clock domain pass two flops
	nand_host_sync #(
		.WIDTH(9)
	) u_sync (
		.clk_i(clk_i),
		.d_i({ready_busy_i, io_in_i}),
		.q_o(sync_q)
	);

	// Strobe and standby phase timer
	nand_host_timer #(
		.W(`TMR_W)
	) u_timer (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.done_o(tmr_done)
	);

	assign io_s = sync_q[7:0];
	assign rdy_s = sync_q[8];
	assign req = wb_cyc_i && wb_stb_i && !r.ack;
	assign go_op = wb_dat_i[2:0];
	// Address bytes inherit the modify nature of the command before them
	assign wr_type = (go_op == `OP_WDATA) || ((go_op == `OP_CMD) && is_write_cmd(r.cmd)) ||
		((go_op == `OP_ADDR) && is_write_cmd(r.last_cmd));

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		n = r;
		tmr_load = 1'b0;
		tmr_count = `TMR_W'(STROBE_CYCLES);
		n.ack = 1'b0;

		// Register access: one-cycle ack, unmapped reads zero
		if (req) begin
			n.ack = 1'b1;
			n.rd_data = 32'h0;
			if (!wb_we_i) begin
				// Reads have no side effects
				if (wb_adr_i == `REG_OP) begin
					n.rd_data[`ST_BUSY] = (r.st != S_IDLE);
					n.rd_data[`ST_READY] = rdy_s;
					n.rd_data[`ST_WP_ERR] = r.wp_err;
					n.rd_data[`ST_PLANE_ERR] = r.plane_err;
					n.rd_data[`ST_BUSY_ERR] = r.busy_err;
					n.rd_data[`ST_STBY] = r.stby_done;
				end else if (wb_adr_i == `REG_CMD) begin
					n.rd_data = {24'h0, r.cmd};
				end else if (wb_adr_i == `REG_ADDR) begin
					n.rd_data = {1'b0, r.addr};
				end else if (wb_adr_i == `REG_WDATA) begin
					n.rd_data = {24'h0, r.wdat};
				end else if (wb_adr_i == `REG_RDATA) begin
					n.rd_data = {24'h0, r.rdat};
				end else if (wb_adr_i == `REG_PINS) begin
					n.rd_data = {31'h0, r.wp_allow};
				end
			end else if (r.st == S_IDLE) begin
				// Writes mid-transfer would tear the pins, so only idle
				if (wb_adr_i == `REG_CMD) begin
					n.cmd = 8'(sel_merge({24'h0, r.cmd}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i == `REG_ADDR) begin
					n.addr = 31'(sel_merge({1'b0, r.addr}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i == `REG_WDATA) begin
					n.wdat = 8'(sel_merge({24'h0, r.wdat}, wb_dat_i, wb_sel_i));
				end else if (wb_adr_i == `REG_PINS && wb_sel_i[0]) begin
					n.wp_allow = wb_dat_i[0];
				end else if (wb_adr_i == `REG_OP && wb_sel_i[0]) begin
					// New operation clears old errors; any new error set after
					n.wp_err = 1'b0;
					n.plane_err = 1'b0;
					n.busy_err = 1'b0;
					n.stby_done = 1'b0;
					if (wr_type && !r.wp_allow) begin
						n.wp_err = 1'b1;
					end else if (go_op == `OP_CMD && !rdy_s && r.cmd != `CMD_RESET &&
						r.cmd != `CMD_STATUS) begin
						n.busy_err = 1'b1;
					end else if (go_op == `OP_CMD && r.cmd == `CMD_DUMMY && r.b19_first) begin
						n.plane_err = 1'b1;
					end else if (go_op == `OP_ADDR && r.last_cmd == `CMD_PROG_P2 &&
						!r.addr[`PLANE_BIT]) begin
						n.plane_err = 1'b1;
					end else if (go_op == `OP_STBY) begin
						// Hold chip select high for the standby time
						n.st = S_STBY;
						n.ce_n = 1'b1;
						tmr_load = 1'b1;
						tmr_count = `TMR_W'(STBY_CYCLES);
					end else if (go_op <= `OP_RDATA) begin
						// Start one bus cycle: selects and data before the strobe
						n.op = go_op;
						n.idx = 3'h0;
						n.st = S_SETUP;
						n.ce_n = 1'b0;
						n.cle = (go_op == `OP_CMD);
						n.ale = (go_op == `OP_ADDR);
						n.io_oe_n = (go_op == `OP_RDATA);
						tmr_load = 1'b1;
						if (go_op == `OP_CMD) begin
							n.io_out = r.cmd;
							n.last_cmd = r.cmd;
						end else if (go_op == `OP_ADDR) begin
							n.io_out = addr_byte(r.addr, 3'h0);
							if (r.last_cmd == `CMD_PROG1) begin
								n.b19_first = r.addr[`PLANE_BIT];
							end
						end else begin
							n.io_out = r.wdat;
						end
					end
				end
			end
		end

		// Bus cycle engine
		case (r.st)
			S_SETUP: begin
				// Setup done: lower the proper strobe
				if (tmr_done) begin
					n.st = S_LOW;
					tmr_load = 1'b1;
					if (r.op == `OP_RDATA) begin
						n.rs_n = 1'b0;
						tmr_count = `TMR_W'(READ_LOW_CYCLES);
					end else begin
						n.we_n = 1'b0;
					end
				end
			end
			S_LOW: begin
				// Rising strobe: device latches, host samples read byte
				if (tmr_done) begin
					n.st = S_HIGH;
					n.we_n = 1'b1;
					n.rs_n = 1'b1;
					tmr_load = 1'b1;
					if (r.op == `OP_RDATA) begin
						n.rdat = io_s;
					end
				end
			end
			S_HIGH: begin
				// Hold after the strobe, then next address byte or finish
				if (tmr_done) begin
					if (r.op == `OP_ADDR && r.idx != `ADDR_LAST) begin
						n.idx = r.idx + 3'h1;
						n.io_out = addr_byte(r.addr, r.idx + 3'h1);
						n.st = S_SETUP;
						tmr_load = 1'b1;
					end else begin
						n.st = S_IDLE;
						n.cle = 1'b0;
						n.ale = 1'b0;
						n.io_oe_n = 1'b1;
					end
				end
			end
			S_STBY: begin
				// Standby hold complete; chip select stays high
				if (tmr_done) begin
					n.st = S_IDLE;
					n.stby_done = 1'b1;
				end
			end
			default: begin
			end
		endcase
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r <= CTL_RESET;
		end else begin
			r <= n;
		end
	end

	// Pins and bus outputs straight from flops
	assign wb_dat_o = r.rd_data;
	assign wb_ack_o = r.ack;
	assign io_out_o = r.io_out;
	assign io_oe_n_o = r.io_oe_n;
	assign cle_o = r.cle;
	assign ale_o = r.ale;
	assign ce_n_o = r.ce_n;
	assign we_n_o = r.we_n;
	assign read_strobe_n_o = r.rs_n;
	assign wp_n_o = r.wp_allow;

	// ****************************************
	// Assertions
	// ****************************************
	localparam int STBY_MIN = STBY_CYCLES - 1;
	logic [`TMR_W-1:0] ce_hi_cnt; // Cycles chip select has been high

	// Helper count for the standby check
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !ce_n_o) begin
			ce_hi_cnt <= '0;
		end else if (ce_hi_cnt != '1) begin
			ce_hi_cnt <= ce_hi_cnt + 1'b1;
		end
	end

	// Standby completion visible in the status flag
	logic stby_flag_seen;
	assign stby_flag_seen = r.stby_done && r.st == S_IDLE;

	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
	a_ack_follows: assert property (req |=> wb_ack_o)
		else $error("request not acked next cycle");
	a_bus_release: assert property (!read_strobe_n_o |-> io_oe_n_o && !ce_n_o)
		else $error("host drives bus during read");
	a_cmd_cycle: assert property ($rose(we_n_o) && cle_o |->
		!ale_o && !ce_n_o && read_strobe_n_o && !io_oe_n_o)
		else $error("bad command cycle");
	a_data_stable: assert property (!we_n_o && !$past(we_n_o) |-> $stable(io_out_o))
		else $error("bus byte changed while write strobe low");
	a_write_prot: assert property ($rose(we_n_o) && !cle_o && !ale_o |-> wp_n_o)
		else $error("data input with write protect low");
	a_addr_pad2: assert property ($rose(we_n_o) && ale_o && r.idx == 3'h1 |->
		io_out_o[7:4] == 4'h0)
		else $error("second address byte upper nibble not low");
	a_addr_pad5: assert property ($rose(we_n_o) && ale_o && r.idx == 3'h4 |->
		io_out_o[7:3] == 5'h00 && io_out_o[2:0] == r.addr[30:28])
		else $error("fifth address byte wrong");
	a_stby_len: assert property (r.st == S_STBY && tmr_done |->
		(ce_n_o && ce_hi_cnt >= STBY_MIN) ##1 stby_flag_seen)
		else $error("standby ended early");
	a_busy_refuse: assert property (req && wb_we_i && wb_adr_i == `REG_OP && wb_sel_i[0] &&
		go_op == `OP_CMD && r.st == S_IDLE && !rdy_s && r.wp_allow &&
		r.cmd != `CMD_RESET && r.cmd != `CMD_STATUS |=> r.busy_err && r.st == S_IDLE)
		else $error("command issued while flash busy");

	c_read_byte: cover property ($rose(read_strobe_n_o));
	c_addr_five: cover property (r.st == S_HIGH && r.idx == 3'h4 && tmr_done);
	c_standby: cover property (r.st == S_STBY && tmr_done);
	c_busy_err: cover property (!r.busy_err ##1 r.busy_err);
endmodule : nand_host_ctrl

// ==== core/nand_host_params.svh ====
// Offsets, field positions, command codes and timing counts of the NAND host controller
`ifndef NAND_HOST_PARAMS_SVH
`define NAND_HOST_PARAMS_SVH

// ****************************************
// Register byte offsets (Wishbone side)
// ****************************************
`define REG_OP 6'h00
`define REG_CMD 6'h04
`define REG_ADDR 6'h08
`define REG_WDATA 6'h0c
`define REG_RDATA 6'h10
`define REG_PINS 6'h14

// ****************************************
// Operation codes and status bits
// ****************************************
`define OP_CMD 3'h0
`define OP_ADDR 3'h1
`define OP_WDATA 3'h2
`define OP_RDATA 3'h3
`define OP_STBY 3'h4
`define ST_BUSY 0
`define ST_READY 1
`define ST_WP_ERR 2
`define ST_PLANE_ERR 3
`define ST_BUSY_ERR 4
`define ST_STBY 5

// ****************************************
// Flash command codes
// ****************************************
`define CMD_READ1 8'h00
`define CMD_READ2 8'h30
`define CMD_PROG1 8'h80
`define CMD_PROG2 8'h10
`define CMD_DUMMY 8'h11
`define CMD_PROG_P2 8'h81
`define CMD_ERASE1 8'h60
`define CMD_ERASE2 8'hd0
`define CMD_READ_ID 8'h90
`define CMD_STATUS 8'h70
`define CMD_RESET 8'hff
`define CMD_COL_RD1 8'h05
`define CMD_COL_RD2 8'he0
`define CMD_COL_WR 8'h85

// ****************************************
// Address layout and timing
// ****************************************
`define ADDR_LAST 3'h4
`define PLANE_BIT 19
`define CLK_PERIOD_NS 5
`define STROBE_NS 25
`define STROBE_CYC ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES 2
`define STBY_US 10
`define STBY_CYC ((`STBY_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TMR_W 12

`endif

// ==== core/nand_host_pkg.sv ====
// Types shared by the NAND host controller modules
package nand_host_pkg;
`include "nand_host_params.svh"

	// Engine states
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH, S_STBY} ctl_st_type;

	// Whole state of the controller
	typedef struct packed {
		ctl_st_type st;
		logic [2:0] op;
		logic [7:0] cmd;
		logic [30:0] addr;
		logic [7:0] wdat;
		logic [7:0] rdat;
		logic [2:0] idx;
		logic [7:0] last_cmd;
		logic b19_first;
		logic wp_allow;
		logic wp_err;
		logic plane_err;
		logic busy_err;
		logic stby_done;
		logic ack;
		logic [31:0] rd_data;
		logic [7:0] io_out;
		logic io_oe_n;
		logic cle;
		logic ale;
		logic ce_n;
		logic we_n;
		logic rs_n;
	} ctl_state_type;

	// Pins idle and released, write protect asserted
	localparam ctl_state_type CTL_RESET = '{st: S_IDLE, io_oe_n: 1'b1, ce_n: 1'b1,
		we_n: 1'b1, rs_n: 1'b1, default: '0};

endpackage : nand_host_pkg

// ==== core/nand_host_sync.sv ====
// Two-stage synchroniser for the flash pins read by the controller
`timescale 1ns/1ps
module nand_host_sync #(
	parameter int WIDTH = 9
) (
	input wire logic clk_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);
	// First stage feeds only the second
	logic [2*WIDTH-1:0] pipe_reg;

	// ****************************************
	// Shift the pins through two flops
	// ****************************************
	always_ff @(posedge clk_i) begin
		pipe_reg <= {pipe_reg[WIDTH-1:0], d_i};
	end

	assign q_o = pipe_reg[2*WIDTH-1:WIDTH];
endmodule : nand_host_sync

// ==== core/nand_host_timer.sv ====
// Down counter that times strobe phases and the standby hold
`timescale 1ns/1ps
module nand_host_timer #(
	parameter int W = 12
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] count_i,
	output logic done_o
);
	// Remaining cycles of the phase
	logic [W-1:0] cnt_reg;

	// ****************************************
	// Load, then count down to zero
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt_reg <= '0;
		end else if (load_i) begin
			cnt_reg <= count_i;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end
	end

	// Phase loaded with N lasts exactly N cycles
	assign done_o = (cnt_reg == {{(W-1){1'b0}}, 1'b1});
endmodule : nand_host_timer

// ==== tb/nand_flash_model.sv ====
// Behavioural flash device facing the host controller
`timescale 1ns/1ps
module nand_flash_model #(
	parameter int BUSY_NS = 1000,
	parameter logic [7:0] ID_BYTE = 8'h5e // Arbitrary identification value
) (
	input wire logic [7:0] io_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic ce_n_i,
	input wire logic we_n_i,
	input wire logic read_strobe_n_i,
	input wire logic wp_n_i,
	output logic [7:0] dout_o,
	output logic doe_n_o,
	output logic rb_low_o
);
	logic [7:0] last_cmd = 8'h00; // Last accepted command
	logic [7:0] ab [5]; // Address bytes as latched
	logic [7:0] wd = 8'h00; // Last program data byte
	logic [11:0] col = 12'h000; // Column counter
	logic [1:0] mode = 2'h0; // Output source: page, status, id
	logic busy = 1'b0;
	int ai = 0;
	event kick;
	// ****************************************
	// Busy timer, blind to chip select so a deselect cannot abort it
	// ****************************************
	always begin
		@(kick);
		busy = 1'b1;
		#(BUSY_NS);
		busy = 1'b0;
	end
	assign rb_low_o = busy; // Pulls low only, bench supplies the pull-up
	assign doe_n_o = ce_n_i | read_strobe_n_i; // Floats when deselected
	// Capture on strobe rise, only with chip select low and read strobe high
	always @(posedge we_n_i) begin
		if (!ce_n_i && read_strobe_n_i) begin
			if (cle_i && !ale_i) begin
				if (!busy || io_i == 8'hff || io_i == 8'h70) begin
					case (io_i) // Unknown codes fall through untouched
						8'h00, 8'h05, 8'h80, 8'h81, 8'h60, 8'h85: begin
							ai = 0;
							last_cmd = io_i;
						end
						8'h30, 8'he0: begin
							col = {ab[1][3:0], ab[0]};
							mode = 2'h0;
							last_cmd = io_i;
							if (io_i == 8'h30) -> kick;
						end
						8'h10, 8'h11, 8'hd0, 8'hff: begin
							last_cmd = io_i;
							if (wp_n_i || io_i == 8'hff) -> kick;
						end
						8'h70, 8'h90: begin
							mode = (io_i == 8'h70) ? 2'h1 : 2'h2;
							last_cmd = io_i;
						end
						default: ;
					endcase
				end
			end else if (ale_i && !cle_i && !busy && ai < 5) begin
				ab[ai] = io_i;
				ai++;
			end else if (!ale_i && !cle_i && wp_n_i && !busy) begin
				wd = io_i;
			end
		end
	end
	// One byte per read strobe fall; status has ready on bit 6, pass on bit 0
	always @(negedge read_strobe_n_i) begin
		if (!ce_n_i) begin
			case (mode)
				2'h1: dout_o = {1'b0, !busy, 6'h00};
				2'h2: dout_o = ID_BYTE;
				default: begin
					dout_o = col[7:0] ^ 8'h5a;
					col++;
				end
			endcase
		end
	end
endmodule : nand_flash_model

// ==== tb/tb_top.sv ====
// Top testbench: host controller, flash model, scenario tasks
`timescale 1ns/1ps
`include "nand_host_params.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	localparam logic [30:0] PA = 31'h3bc56123; // Program page, plane bit clear
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [5:0] adr = 6'h00;
	logic [31:0] wdat = 32'h0, rd, st;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, io_oe_n_o, cle_o, ale_o, ce_n_o, we_n_o, rs_n_o, wp_n_o, doe_n, rb_low;
	logic [7:0] io_out_o, dout, bus_last = 8'h00;
	int errors = 0;
	int samples_checked = 0;
	// Released wire shows a changing pattern, never a stale byte
	wire [7:0] bus = !io_oe_n_o ? io_out_o : !doe_n ? dout : ~bus_last;
	wire ready = rb_low ? 1'b0 : 1'b1; // Pull-up on the shared line
	always @(posedge clk_i) bus_last <= bus;
	initial forever #2.5 clk_i = ~clk_i;
	// Short standby hold keeps the run brief
	nand_host_ctrl #(.STBY_CYCLES(20)) nand_host_ctrl_inst (.clk_i(clk_i),
		.sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .io_in_i(bus), .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o),
		.cle_o(cle_o), .ale_o(ale_o), .ce_n_o(ce_n_o), .we_n_o(we_n_o),
		.read_strobe_n_o(rs_n_o), .wp_n_o(wp_n_o), .ready_busy_i(ready));
	nand_flash_model nand_flash_model_inst (.io_i(bus), .cle_i(cle_o), .ale_i(ale_o),
		.ce_n_i(ce_n_o), .we_n_i(we_n_o), .read_strobe_n_i(rs_n_o), .wp_n_i(wp_n_o),
		.dout_o(dout), .doe_n_o(doe_n), .rb_low_o(rb_low));
	// ****************************************
	// Bus and operation tasks
	// ****************************************
	// Classic cycle held until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// No cycle count assumed: only the watchdog ends this wait
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	// Load operand unless read or standby, start, poll until the engine is idle
	task automatic op(input logic [2:0] c, input logic [5:0] a, input logic [31:0] v);
		int n;
		n = 0;
		if (c != `OP_RDATA && c != `OP_STBY) wb(1'b1, a, v);
		wb(1'b1, `REG_OP, {29'h0, c});
		do begin
			wb(1'b0, `REG_OP, 32'h0);
			n++;
		end while (rd[`ST_BUSY] !== 1'b0 && n < 3000);
		// Engine never went idle: a spent limit is a mismatch
		if (rd[`ST_BUSY] !== 1'b0) begin
			errors++;
		end
		st = rd;
	endtask : op
	task automatic cmd(input logic [7:0] c);
		op(`OP_CMD, `REG_CMD, {24'h0, c});
	endtask : cmd
	task automatic rdbyte();
		op(`OP_RDATA, `REG_RDATA, 32'h0);
		wb(1'b0, `REG_RDATA, 32'h0);
	endtask : rdbyte
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			wb(1'b0, `REG_OP, 32'h0);
			n++;
		end while (rd[`ST_READY] !== 1'b1 && n < 3000);
		// Flash stayed busy: a spent limit is a mismatch
		if (rd[`ST_READY] !== 1'b1) begin
			errors++;
		end
	endtask : wait_rdy
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_protect();
		`CHK(wp_n_o, 1'b0)
		wb(1'b0, 6'h3c, 32'h0);
		`CHK(rd, 32'h0)
		cmd(8'h80);
		`CHK(st[`ST_WP_ERR], 1'b1)
		`CHK(nand_flash_model_inst.last_cmd, 8'h00)
		wb(1'b1, `REG_PINS, 32'h1);
		$display("done: protect");
	endtask : t_protect
	task automatic t_program();
		cmd(8'h80);
		op(`OP_ADDR, `REG_ADDR, {1'b0, PA});
		`CHK(nand_flash_model_inst.ab[0], PA[7:0])
		`CHK(nand_flash_model_inst.ab[1], {4'h0, PA[11:8]})
		`CHK(nand_flash_model_inst.ab[2], PA[19:12])
		`CHK(nand_flash_model_inst.ab[3], PA[27:20])
		`CHK(nand_flash_model_inst.ab[4], {5'h00, PA[30:28]})
		op(`OP_WDATA, `REG_WDATA, 32'h3c);
		`CHK(nand_flash_model_inst.wd, 8'h3c)
		cmd(8'h10);
		`CHK(ready, 1'b0)
		cmd(8'h90);
		`CHK(st[`ST_BUSY_ERR], 1'b1)
		cmd(8'h70);
		rdbyte();
		`CHK(rd[7:0], 8'h00)
		wait_rdy();
		rdbyte();
		`CHK(rd[7:0], 8'h40)
		$display("done: program");
	endtask : t_program
	task automatic t_read();
		cmd(8'h00);
		op(`OP_ADDR, `REG_ADDR, 32'h123);
		cmd(8'h30);
		wait_rdy();
		rdbyte();
		`CHK(rd[7:0], 8'h23 ^ 8'h5a)
		rdbyte();
		`CHK(rd[7:0], 8'h24 ^ 8'h5a)
		cmd(8'h05);
		op(`OP_ADDR, `REG_ADDR, 32'h7f0);
		cmd(8'he0);
		rdbyte();
		`CHK(rd[7:0], 8'hf0 ^ 8'h5a)
		cmd(8'h90);
		rdbyte();
		`CHK(rd[7:0], 8'h5e)
		$display("done: read");
	endtask : t_read
	task automatic t_codes();
		logic [7:0] codes [15] = '{8'h00, 8'h30, 8'h05, 8'he0, 8'h80, 8'h11, 8'h81,
			8'h10, 8'h85, 8'h60, 8'h60, 8'hd0, 8'h90, 8'h70, 8'hff};
		foreach (codes[i]) begin
			cmd(codes[i]);
			wait_rdy();
			`CHK(nand_flash_model_inst.last_cmd, codes[i])
		end
		cmd(8'h3a);
		`CHK(nand_flash_model_inst.last_cmd, 8'hff)
		$display("done: codes");
	endtask : t_codes
	task automatic t_plane();
		cmd(8'h80);
		op(`OP_ADDR, `REG_ADDR, 32'h0008_0000);
		cmd(8'h11);
		`CHK(st[`ST_PLANE_ERR], 1'b1)
		`CHK(nand_flash_model_inst.last_cmd, 8'h80)
		cmd(8'hff);
		wait_rdy();
		op(`OP_STBY, `REG_OP, 32'h0);
		`CHK(st[`ST_STBY], 1'b1)
		`CHK(ce_n_o, 1'b1)
		`CHK(doe_n, 1'b1)
		$display("done: plane and standby");
	endtask : t_plane
	// ****************************************
	// Verdict, watchdog and main sequence
	// ****************************************
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		t_protect();
		t_program();
		t_read();
		t_codes();
		t_plane();
		report_and_stop();
	end
endmodule : tb_top
